// ==== gdcr_host.sv ====
// Host model that drives the register port of the configuration bank.
module gdcr_host
(
   // Clock.
   input wire logic core_clk,
   // Register port towards the device.
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Port access
   // ==========================================================================
   // The port starts quiet, so reset and the first read never see an unknown strobe.
   initial
   begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // The write strobe is left high so back-to-back writes need no idle cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
   endtask
   // Dropping the strobe inverts the data, so a stale byte never looks valid.
   task automatic idle();
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
   endtask
   // Read data is combinational, so it is taken once the address has settled.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b0; // A read straight after a write must not write the read offset.
      reg_addr = a;
      #1 d = reg_rdata;
   endtask
endmodule // gdcr_host

// ==== gdcr_pkg.sv ====
// Package of offsets, field layouts and reset values for the gate drive configuration registers.
package gdcr_pkg;
   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [7:0] OFS_SRC_A = 8'h06;
   localparam logic [7:0] OFS_SRC_B = 8'h07;
   localparam logic [7:0] OFS_SRC_C = 8'h08;
   localparam logic [7:0] OFS_OCP_A = 8'h09;

   // ==========================================================================
   // Reset values and field layout
   // ==========================================================================
   localparam logic [7:0] RST_SRC = 8'hff;
   localparam logic [7:0] RST_OCP = 8'h99;
   localparam int LOW_MSB = 7;
   localparam int LOW_LSB = 4;
   localparam int HIGH_MSB = 3;
   localparam int HIGH_LSB = 0;
   // Codes at or below this value are the four weakest source currents.
   localparam logic [3:0] WEAK_CODE_MAX = 4'h3;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : gdcr_pkg

// ==== gdcr_regs.sv ====
// Gate drive source current and overcurrent threshold configuration registers.
module gdcr_regs
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port, same clock domain as the serial decoder.
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Drive time limit enable written elsewhere, and the forced result.
   input wire logic drive_time_limit_enable_sw,
   output logic drive_time_limit_enable,
   // Settings to the analog gate drive.
   output logic [3:0] low_side_source_current_a,
   output logic [3:0] high_side_source_current_a,
   output logic [3:0] low_side_source_current_b,
   output logic [3:0] high_side_source_current_b,
   output logic [3:0] low_side_source_current_c,
   output logic [3:0] high_side_source_current_c,
   // Settings to the overcurrent comparators.
   output logic [3:0] low_side_overcurrent_threshold_a,
   output logic [3:0] high_side_overcurrent_threshold_a
);
   // ==========================================================================
   // Storage
   // ==========================================================================
   // Stored register bytes.
   logic [7:0] gate_source_current_phase_a;
   logic [7:0] gate_source_current_phase_b;
   logic [7:0] gate_source_current_phase_c;
   logic [7:0] overcurrent_threshold_phase_a;

   // Next values from the write decode.
   logic [7:0] next_src_a;
   logic [7:0] next_src_b;
   logic [7:0] next_src_c;
   logic [7:0] next_ocp_a;
   // Set while any source field holds one of the weak codes.
   logic weak_code;

   // True when a current code is one of the four weakest settings.
   function automatic logic gdcr_is_weak(input logic [3:0] code);
      gdcr_is_weak = (code <= gdcr_pkg::WEAK_CODE_MAX);
   endfunction

   // Upper nibble of a register byte, which always feeds the low-side switch.
   function automatic logic [3:0] gdcr_low_field(input logic [7:0] value);
      gdcr_low_field = value[gdcr_pkg::LOW_MSB:gdcr_pkg::LOW_LSB];
   endfunction

   // Lower nibble of a register byte, which always feeds the high-side switch.
   function automatic logic [3:0] gdcr_high_field(input logic [7:0] value);
      gdcr_high_field = value[gdcr_pkg::HIGH_MSB:gdcr_pkg::HIGH_LSB];
   endfunction

   // ==========================================================================
   // Register write
   // ==========================================================================
   // Write decode; a write to any other offset is ignored.
   always_comb
   begin
      next_src_a = gate_source_current_phase_a;
      next_src_b = gate_source_current_phase_b;
      next_src_c = gate_source_current_phase_c;
      next_ocp_a = overcurrent_threshold_phase_a;
      if (reg_wr)
      begin
         case (reg_addr)
            gdcr_pkg::OFS_SRC_A: next_src_a = reg_wdata;
            gdcr_pkg::OFS_SRC_B: next_src_b = reg_wdata;
            gdcr_pkg::OFS_SRC_C: next_src_c = reg_wdata;
            gdcr_pkg::OFS_OCP_A: next_ocp_a = reg_wdata;
            default: ;
         endcase
      end
   end

   // Registers with their documented reset values.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         gate_source_current_phase_a <= gdcr_pkg::RST_SRC;
         gate_source_current_phase_b <= gdcr_pkg::RST_SRC;
         gate_source_current_phase_c <= gdcr_pkg::RST_SRC;
         overcurrent_threshold_phase_a <= gdcr_pkg::RST_OCP;
      end
      else
      begin
         gate_source_current_phase_a <= next_src_a;
         gate_source_current_phase_b <= next_src_b;
         gate_source_current_phase_c <= next_src_c;
         overcurrent_threshold_phase_a <= next_ocp_a;
      end
   end

   // ==========================================================================
   // Read mux and field outputs
   // ==========================================================================
   // Read data is combinational so the serial shifter can load it in the address cycle.
   always_comb
   begin
      case (reg_addr)
         gdcr_pkg::OFS_SRC_A: reg_rdata = gate_source_current_phase_a;
         gdcr_pkg::OFS_SRC_B: reg_rdata = gate_source_current_phase_b;
         gdcr_pkg::OFS_SRC_C: reg_rdata = gate_source_current_phase_c;
         gdcr_pkg::OFS_OCP_A: reg_rdata = overcurrent_threshold_phase_a;
         default: reg_rdata = gdcr_pkg::READ_UNMAPPED;
      endcase
   end

   // Fields come straight from the flops, so the analog side sees no glitch.
   always_comb
   begin
      low_side_source_current_a = gdcr_low_field(gate_source_current_phase_a);
      high_side_source_current_a = gdcr_high_field(gate_source_current_phase_a);
      low_side_source_current_b = gdcr_low_field(gate_source_current_phase_b);
      high_side_source_current_b = gdcr_high_field(gate_source_current_phase_b);
      low_side_source_current_c = gdcr_low_field(gate_source_current_phase_c);
      high_side_source_current_c = gdcr_high_field(gate_source_current_phase_c);
      low_side_overcurrent_threshold_a = gdcr_low_field(overcurrent_threshold_phase_a);
      high_side_overcurrent_threshold_a = gdcr_high_field(overcurrent_threshold_phase_a);
   end

   // ==========================================================================
   // Drive time limit
   // ==========================================================================
   // A weak code could leave a gate half charged, so the time limit is forced on.
   always_comb
   begin
      weak_code = gdcr_is_weak(low_side_source_current_a) | gdcr_is_weak(high_side_source_current_a)
         | gdcr_is_weak(low_side_source_current_b) | gdcr_is_weak(high_side_source_current_b)
         | gdcr_is_weak(low_side_source_current_c) | gdcr_is_weak(high_side_source_current_c);
      drive_time_limit_enable = drive_time_limit_enable_sw | weak_code;
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   // Reset brings every register byte back to its default, seen at the field outputs.
   a_src_a_reset: assert property (@(posedge core_clk)
      rst |=> {low_side_source_current_a, high_side_source_current_a} == gdcr_pkg::RST_SRC)
      else $error("Phase A source current not at default after reset.");
   a_src_b_reset: assert property (@(posedge core_clk)
      rst |=> {low_side_source_current_b, high_side_source_current_b} == gdcr_pkg::RST_SRC)
      else $error("Phase B source current not at default after reset.");
   a_src_c_reset: assert property (@(posedge core_clk)
      rst |=> {low_side_source_current_c, high_side_source_current_c} == gdcr_pkg::RST_SRC)
      else $error("Phase C source current not at maximum after reset.");
   a_ocp_reset: assert property (@(posedge core_clk)
      rst |=> {low_side_overcurrent_threshold_a, high_side_overcurrent_threshold_a} == gdcr_pkg::RST_OCP)
      else $error("Overcurrent threshold not at default after reset.");

   // A write lands at the next edge as a whole byte, upper nibble to the low side.
   a_src_a_write: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == gdcr_pkg::OFS_SRC_A
         |=> {low_side_source_current_a, high_side_source_current_a} == $past(reg_wdata))
      else $error("Phase A source current write not applied.");
   a_src_b_write: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == gdcr_pkg::OFS_SRC_B
         |=> {low_side_source_current_b, high_side_source_current_b} == $past(reg_wdata))
      else $error("Phase B source current write not applied.");
   a_src_c_write: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == gdcr_pkg::OFS_SRC_C
         |=> {low_side_source_current_c, high_side_source_current_c} == $past(reg_wdata))
      else $error("Phase C source current write not applied.");
   a_ocp_write: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == gdcr_pkg::OFS_OCP_A
         |=> {low_side_overcurrent_threshold_a, high_side_overcurrent_threshold_a} == $past(reg_wdata))
      else $error("Overcurrent threshold write not applied.");

   // Without a write to its own offset a register keeps its value, even across other writes.
   a_src_a_hold: assert property (@(posedge core_clk) disable iff (rst)
      !(reg_wr && reg_addr == gdcr_pkg::OFS_SRC_A) |=> $stable(gate_source_current_phase_a))
      else $error("Phase A source current changed without a write.");
   a_src_b_hold: assert property (@(posedge core_clk) disable iff (rst)
      !(reg_wr && reg_addr == gdcr_pkg::OFS_SRC_B) |=> $stable(gate_source_current_phase_b))
      else $error("Phase B source current changed without a write.");
   a_src_c_hold: assert property (@(posedge core_clk) disable iff (rst)
      !(reg_wr && reg_addr == gdcr_pkg::OFS_SRC_C) |=> $stable(gate_source_current_phase_c))
      else $error("Phase C source current changed without a write.");
   a_ocp_hold: assert property (@(posedge core_clk) disable iff (rst)
      !(reg_wr && reg_addr == gdcr_pkg::OFS_OCP_A) |=> $stable(overcurrent_threshold_phase_a))
      else $error("Overcurrent threshold changed without a write.");

   // Read data follows the stored byte, and offsets outside the bank read as zero.
   a_src_a_readback: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == gdcr_pkg::OFS_SRC_A
         |=> reg_addr != gdcr_pkg::OFS_SRC_A || reg_rdata == $past(reg_wdata))
      else $error("Readback of phase A register wrong.");
   a_src_b_readback: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == gdcr_pkg::OFS_SRC_B
         |=> reg_addr != gdcr_pkg::OFS_SRC_B || reg_rdata == $past(reg_wdata))
      else $error("Readback of phase B register wrong.");
   a_src_c_readback: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == gdcr_pkg::OFS_SRC_C
         |=> reg_addr != gdcr_pkg::OFS_SRC_C || reg_rdata == $past(reg_wdata))
      else $error("Readback of phase C register wrong.");
   a_ocp_readback: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == gdcr_pkg::OFS_OCP_A
         |=> reg_addr != gdcr_pkg::OFS_OCP_A || reg_rdata == $past(reg_wdata))
      else $error("Readback of overcurrent threshold register wrong.");
   a_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
      reg_addr < gdcr_pkg::OFS_SRC_A || reg_addr > gdcr_pkg::OFS_OCP_A
         |-> reg_rdata == gdcr_pkg::READ_UNMAPPED)
      else $error("Unmapped offset did not read as zero.");

   // The limit enable is forced by any weak code and otherwise passes the software bit.
   a_weak_force: assert property (@(posedge core_clk) disable iff (rst)
      (low_side_source_current_a <= gdcr_pkg::WEAK_CODE_MAX
         || high_side_source_current_a <= gdcr_pkg::WEAK_CODE_MAX
         || low_side_source_current_b <= gdcr_pkg::WEAK_CODE_MAX
         || high_side_source_current_b <= gdcr_pkg::WEAK_CODE_MAX
         || low_side_source_current_c <= gdcr_pkg::WEAK_CODE_MAX
         || high_side_source_current_c <= gdcr_pkg::WEAK_CODE_MAX)
         |-> drive_time_limit_enable)
      else $error("Drive time limit not forced for weak code.");
   a_limit_follow: assert property (@(posedge core_clk) disable iff (rst)
      (low_side_source_current_a > gdcr_pkg::WEAK_CODE_MAX
         && high_side_source_current_a > gdcr_pkg::WEAK_CODE_MAX
         && low_side_source_current_b > gdcr_pkg::WEAK_CODE_MAX
         && high_side_source_current_b > gdcr_pkg::WEAK_CODE_MAX
         && low_side_source_current_c > gdcr_pkg::WEAK_CODE_MAX
         && high_side_source_current_c > gdcr_pkg::WEAK_CODE_MAX)
         |-> drive_time_limit_enable == drive_time_limit_enable_sw)
      else $error("Drive time limit forced without a weak code.");
   a_limit_sw: assert property (@(posedge core_clk) disable iff (rst)
      drive_time_limit_enable_sw |-> drive_time_limit_enable)
      else $error("Software drive time limit enable not passed on.");
endmodule // gdcr_regs

// ==== testbench.sv ====
// Self-checking testbench for the gate drive configuration registers.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic sw = 1'b0;
   logic reg_wr;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic tle;
   wire [7:0][3:0] f;
   logic [7:0] v;
   int mismatches = 0;
   int tests_run = 0;
   // ==========================================================================
   // Clock, host and device
   // ==========================================================================
   always #5 core_clk = ~core_clk;
   gdcr_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));
   gdcr_regs dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .drive_time_limit_enable_sw(sw), .drive_time_limit_enable(tle),
      .low_side_source_current_a(f[0]), .high_side_source_current_a(f[1]), .low_side_source_current_b(f[2]),
      .high_side_source_current_b(f[3]), .low_side_source_current_c(f[4]), .high_side_source_current_c(f[5]),
      .low_side_overcurrent_threshold_a(f[6]), .high_side_overcurrent_threshold_a(f[7]));
   // Compare one byte and count it.
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // Register i is checked both through the read port and through its two field outputs.
   task automatic reg_chk(input int i, input logic [7:0] e);
      logic [7:0] d;
      host.rd(gdcr_pkg::OFS_SRC_A + 8'(i), d);
      chk("rdata", d, e);
      chk("fields", {f[2*i], f[2*i+1]}, e);
   endtask
   // Print the counts and the verdict, then stop.
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Main sequence; a second reset in mid-run must restore the defaults as well.
   initial
   begin
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) reg_chk(i, i == 3 ? gdcr_pkg::RST_OCP : gdcr_pkg::RST_SRC);
      chk("limit", {7'h0, tle}, 8'h00);
      $display("test defaults done");
      for (int i = 0; i < 4; i++) host.wr(gdcr_pkg::OFS_SRC_A + 8'(i), 8'h5a + 8'(17 * i));
      host.idle();
      chk("threshold next cycle", {f[6], f[7]}, 8'h8d);
      host.wr(8'h05, 8'h00);
      host.wr(8'h0a, 8'h00);
      host.idle();
      for (int j = 0; j < 3; j++)
      begin
         host.rd(j == 0 ? 8'h05 : (j == 1 ? 8'h0a : 8'hff), v);
         chk("unmapped", v, gdcr_pkg::READ_UNMAPPED);
      end
      for (int i = 0; i < 4; i++) reg_chk(i, 8'h5a + 8'(17 * i));
      chk("limit", {7'h0, tle}, 8'h00);
      $display("test write readback done");
      for (int r = 0; r < 6; r++)
         for (int c = 0; c < 16; c++)
         begin
            host.wr(gdcr_pkg::OFS_SRC_A + 8'(r / 2), r % 2 == 0 ? {4'(c), 4'hf} : {4'hf, 4'(c)});
            host.idle();
            chk("limit", {7'h0, tle}, {7'h0, c <= 3});
         end
      sw = 1'b1;
      #1 chk("limit sw", {7'h0, tle}, 8'h01);
      $display("test limit forcing done");
      @(negedge core_clk) rst = 1'b1;
      @(negedge core_clk) rst = 1'b0;
      for (int i = 0; i < 4; i++) reg_chk(i, i == 3 ? gdcr_pkg::RST_OCP : gdcr_pkg::RST_SRC);
      $display("test second reset done");
      report_and_stop();
   end
   // Watchdog well beyond the few hundred cycles the tests need.
   initial
   begin
      #50000;
      mismatches++;
      report_and_stop();
   end
endmodule // testbench
